// >>> rtl/msp_pkg.sv
// Purpose: Shared types and timing counts for the MAC-side pin mux.
// Assumes: One 250 MHz system clock drives both ends.
// Notes:   Clock periods are counted in system cycles.
package msp_pkg;

    // Interface type carried by the multiplexed pins.
    typedef enum logic [2:0] {
        MSP_RGMII,
        MSP_RMII,
        MSP_RTBI,
        MSP_SGMII,
        MSP_BASEX
    } msp_mode_t;

    // Line speed, meaningful for the reduced gigabit interface only.
    typedef enum logic [1:0] {
        MSP_SPD_1000,
        MSP_SPD_100,
        MSP_SPD_10
    } msp_speed_t;

    // Clock rates in kHz and the derived periods in system cycles.
    localparam int SYS_CLK_KHZ = 250000;
    localparam int GIG_CLK_KHZ = 125000;
    localparam int FAST_CLK_KHZ = 25000;
    localparam int SLOW_CLK_KHZ = 2500;
    localparam int REF_CLK_KHZ = 50000;
    localparam logic [7:0] PER_GIG = 8'(SYS_CLK_KHZ / GIG_CLK_KHZ);
    localparam logic [7:0] PER_FAST = 8'(SYS_CLK_KHZ / FAST_CLK_KHZ);
    localparam logic [7:0] PER_SLOW = 8'(SYS_CLK_KHZ / SLOW_CLK_KHZ);
    localparam logic [7:0] PER_REF = 8'(SYS_CLK_KHZ / REF_CLK_KHZ);
    localparam logic [7:0] PER_NONE = 8'h00;

    // Clock period for a mode and speed; zero means the clock stands low.
    function automatic logic [7:0] msp_period(msp_mode_t m, msp_speed_t s);
        case (m)
            MSP_RTBI: return PER_GIG;
            MSP_RMII: return PER_REF;
            MSP_RGMII: begin
                case (s)
                    MSP_SPD_1000: return PER_GIG;
                    MSP_SPD_100:  return PER_FAST;
                    default:      return PER_SLOW;
                endcase
            end
            default: return PER_NONE;
        endcase
    endfunction

    // Next divider count; wraps at the period.
    function automatic logic [7:0] msp_count_next(logic [7:0] cnt,
                                                  logic [7:0] per);
        if (per == PER_NONE || cnt >= per - 8'h01) begin
            return 8'h00;
        end
        return cnt + 8'h01;
    endfunction

    // Clock level for a count; odd periods stay high the longer half.
    function automatic logic msp_level(logic [7:0] cnt, logic [7:0] per);
        return (per != PER_NONE) && (cnt < per - (per >> 1));
    endfunction

endpackage

// >>> rtl/msp_pins_if.sv
// Purpose: The MAC-facing pins shared by the PHY end and the MAC end.
// Assumes: Undriven two-way pins read low, as with a pull-down.
// Notes:   Two-way pins carry an output and an enable from each end.
`timescale 1ns/1ns
`default_nettype none
interface msp_pins_if;

    // Transmit-clock pin: MAC clock in, or positive serial clock out.
    logic       clk_mac_o;
    logic       clk_mac_oe;
    logic       clk_phy_o;
    logic       clk_phy_oe;
    logic       mac_transmit_timing_clock;
    // Transmit-bit-3 pin: data in, negative serial clock, or detect.
    logic       bit3_mac_o;
    logic       bit3_mac_oe;
    logic       bit3_phy_o;
    logic       bit3_phy_oe;
    logic       transmit_bit3_pin;
    // One-way pins from the MAC.
    logic       transmit_enable_control;
    logic [2:0] transmit_low_bits;
    // One-way pins from the PHY.
    logic       phy_receive_timing_clock;
    logic       receive_enable_control;
    logic [3:0] receive_bits;

    // Wire levels worked out from the enables.
    assign mac_transmit_timing_clock = clk_phy_oe ? clk_phy_o :
                                       (clk_mac_oe & clk_mac_o);
    assign transmit_bit3_pin = bit3_phy_oe ? bit3_phy_o :
                               (bit3_mac_oe & bit3_mac_o);

    modport phy (
        input  mac_transmit_timing_clock, transmit_bit3_pin,
        input  transmit_enable_control, transmit_low_bits,
        output clk_phy_o, clk_phy_oe, bit3_phy_o, bit3_phy_oe,
        output phy_receive_timing_clock, receive_enable_control,
        output receive_bits
    );

    modport mac (
        input  phy_receive_timing_clock, receive_enable_control,
        input  receive_bits, transmit_bit3_pin,
        output clk_mac_o, clk_mac_oe, bit3_mac_o, bit3_mac_oe,
        output transmit_enable_control, transmit_low_bits
    );

endinterface
`default_nettype wire

// >>> rtl/msp_phy_end.sv
// Purpose: PHY end of the MAC-side pins, muxed by interface type.
// Assumes: Link pins arrive asynchronously and are synchronised here.
// Notes:   The serial clock pair toggles at the fastest rate the system
//          clock allows; the true serial rate comes from the serializer.
// Notes on behaviour
// - MAC sends continuous speed-matched transmit clock.
// - Transmit control and nibble sampled on that clock.
// - PHY drives continuous speed-matched receive clock.
// - RMII shares one 50 MHz reference clock.
// - RMII may output free-running 50 MHz receive clock.
// - RTBI transmit clock is always 125 MHz.
// - RTBI receive clock is always 125 MHz.
// - RTBI bit3 pin: rise bit3, fall bit8.
// - RMII bit3 input unused, driven low.
// - SGMII drives serial clock pair on two pins.
// - SGMII receive clock pin held at zero.
// - 1000BASE-X bit3 pin is polarity-selectable detect.
// - Pin function and direction follow interface type.
`timescale 1ns/1ns
`default_nettype none
module msp_phy_end
    import msp_pkg::*;
(
    // System
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Configuration
    input  wire msp_mode_t  i_mode,
    input  wire msp_speed_t i_speed,
    input  wire logic       i_fifty_mhz_clock_output_enable,
    input  wire logic       i_detect_active_low,
    // Transmit data toward the core
    output logic [3:0]      o_tx_rise,
    output logic [3:0]      o_tx_fall,
    output logic            o_tx_ctl_rise,
    output logic            o_tx_ctl_fall,
    output logic            o_tx_strobe,
    // Receive data from the core
    input  wire logic [3:0] i_rx_rise,
    input  wire logic [3:0] i_rx_fall,
    input  wire logic       i_rx_ctl_rise,
    input  wire logic       i_rx_ctl_fall,
    output logic            o_rx_take,
    // Fibre status
    output logic            o_fibre_signal_present,
    // Link pins
    msp_pins_if.phy         pins
);

    // Synchroniser stages; index 0 is read only by index 1.
    logic [2:0] clk_s;
    logic [1:0] bit3_s;
    logic [1:0] ctl_s;
    logic [2:0] low_s0;
    logic [2:0] low_s1;

    // Transmit capture registers.
    logic [3:0] tx_rise;
    logic [3:0] tx_fall;
    logic       ctl_rise;
    logic       ctl_fall;
    logic       tx_strobe;
    logic [3:0] next_tx_rise;
    logic [3:0] next_tx_fall;
    logic       next_ctl_rise;
    logic       next_ctl_fall;
    logic       next_tx_strobe;

    // Receive clock divider and launch registers.
    logic [7:0] rx_cnt;
    logic       rx_clk;
    logic [3:0] rx_bits;
    logic       rx_ctl;
    logic       rx_take;
    logic [7:0] rx_per;
    logic [7:0] next_rx_cnt;
    logic       next_rx_clk;
    logic [3:0] next_rx_bits;
    logic       next_rx_ctl;
    logic       next_rx_take;
    logic       launch_rise;
    logic       launch_fall;

    // Pin direction, serial clock pair and detect registers.
    logic       ser_p;
    logic       ser_n;
    logic       drive_ser;
    logic       present;
    logic       next_ser_p;
    logic       next_ser_n;
    logic       next_drive_ser;
    logic       next_present;

    // Edges of the synchronised transmit clock.
    logic       ref_rise;
    logic       ref_fall;
    logic       tx_mode;

    // Two-flop synchronisers for every pin coming from the link.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            clk_s  <= 3'h0;
            bit3_s <= 2'h0;
            ctl_s  <= 2'h0;
            low_s0 <= 3'h0;
            low_s1 <= 3'h0;
        end else begin
            clk_s  <= {clk_s[1:0], pins.mac_transmit_timing_clock};
            bit3_s <= {bit3_s[0], pins.transmit_bit3_pin};
            ctl_s  <= {ctl_s[0], pins.transmit_enable_control};
            low_s0 <= pins.transmit_low_bits;
            low_s1 <= low_s0;
        end
    end

    // Edges use the second stage and its delayed copy.
    assign ref_rise = clk_s[1] & ~clk_s[2];
    assign ref_fall = ~clk_s[1] & clk_s[2];
    assign tx_mode  = (i_mode == MSP_RGMII) || (i_mode == MSP_RTBI) ||
                      (i_mode == MSP_RMII);

    // Transmit capture on the edges of the MAC's clock.
    always_comb begin
        next_tx_rise   = tx_rise;
        next_tx_fall   = tx_fall;
        next_ctl_rise  = ctl_rise;
        next_ctl_fall  = ctl_fall;
        next_tx_strobe = 1'b0;
        if (!tx_mode) begin
            next_tx_rise  = 4'h0;
            next_tx_fall  = 4'h0;
            next_ctl_rise = 1'b0;
            next_ctl_fall = 1'b0;
        end else if (i_mode == MSP_RMII) begin
            if (ref_rise) begin
                next_tx_rise   = {2'h0, low_s1[1:0]};
                next_ctl_rise  = ctl_s[1];
                next_tx_strobe = 1'b1;
            end
        end else begin
            if (ref_rise) begin
                next_tx_rise  = {bit3_s[1], low_s1};
                next_ctl_rise = ctl_s[1];
            end
            if (ref_fall) begin
                next_tx_fall   = {bit3_s[1], low_s1};
                next_ctl_fall  = ctl_s[1];
                next_tx_strobe = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx_rise   <= 4'h0;
            tx_fall   <= 4'h0;
            ctl_rise  <= 1'b0;
            ctl_fall  <= 1'b0;
            tx_strobe <= 1'b0;
        end else begin
            tx_rise   <= next_tx_rise;
            tx_fall   <= next_tx_fall;
            ctl_rise  <= next_ctl_rise;
            ctl_fall  <= next_ctl_fall;
            tx_strobe <= next_tx_strobe;
        end
    end

    // Receive clock generation and receive data launch.
    always_comb begin
        if (i_mode == MSP_RMII && !i_fifty_mhz_clock_output_enable) begin
            rx_per = PER_NONE;
        end else begin
            rx_per = msp_period(i_mode, i_speed);
        end
        next_rx_cnt = msp_count_next(rx_cnt, rx_per);
        next_rx_clk = msp_level(next_rx_cnt, rx_per);
        if (i_mode == MSP_RMII) begin
            launch_rise = ref_rise;
            launch_fall = 1'b0;
        end else begin
            launch_rise = next_rx_clk & ~rx_clk;
            launch_fall = ~next_rx_clk & rx_clk;
        end
        next_rx_bits = rx_bits;
        next_rx_ctl  = rx_ctl;
        next_rx_take = 1'b0;
        if (!tx_mode) begin
            next_rx_bits = 4'h0;
            next_rx_ctl  = 1'b0;
        end else if (launch_rise) begin
            next_rx_bits = (i_mode == MSP_RMII) ?
                           {2'h0, i_rx_rise[1:0]} : i_rx_rise;
            next_rx_ctl  = i_rx_ctl_rise;
            next_rx_take = (i_mode == MSP_RMII);
        end else if (launch_fall) begin
            next_rx_bits = i_rx_fall;
            next_rx_ctl  = i_rx_ctl_fall;
            next_rx_take = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_cnt  <= 8'h00;
            rx_clk  <= 1'b0;
            rx_bits <= 4'h0;
            rx_ctl  <= 1'b0;
            rx_take <= 1'b0;
        end else begin
            rx_cnt  <= next_rx_cnt;
            rx_clk  <= next_rx_clk;
            rx_bits <= next_rx_bits;
            rx_ctl  <= next_rx_ctl;
            rx_take <= next_rx_take;
        end
    end

    // Pin direction, serial clock pair and fibre detect.
    always_comb begin
        next_drive_ser = (i_mode == MSP_SGMII);
        next_ser_p = next_drive_ser & ~ser_p;
        next_ser_n = next_drive_ser & ser_p;
        next_present = (i_mode == MSP_BASEX) &
                       (bit3_s[1] ^ i_detect_active_low);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ser_p     <= 1'b0;
            ser_n     <= 1'b0;
            drive_ser <= 1'b0;
            present   <= 1'b0;
        end else begin
            ser_p     <= next_ser_p;
            ser_n     <= next_ser_n;
            drive_ser <= next_drive_ser;
            present   <= next_present;
        end
    end

    // Every output comes straight from a register.
    assign o_tx_rise                     = tx_rise;
    assign o_tx_fall                     = tx_fall;
    assign o_tx_ctl_rise                 = ctl_rise;
    assign o_tx_ctl_fall                 = ctl_fall;
    assign o_tx_strobe                   = tx_strobe;
    assign o_rx_take                     = rx_take;
    assign o_fibre_signal_present        = present;
    assign pins.clk_phy_o                = ser_p;
    assign pins.clk_phy_oe               = drive_ser;
    assign pins.bit3_phy_o               = ser_n;
    assign pins.bit3_phy_oe              = drive_ser;
    assign pins.phy_receive_timing_clock = rx_clk;
    assign pins.receive_enable_control   = rx_ctl;
    assign pins.receive_bits             = rx_bits;

endmodule
`default_nettype wire

// >>> rtl/msp_mac_end.sv
// Purpose: MAC end (or fibre module) of the MAC-side pins.
// Assumes: Receive pins arrive asynchronously and are synchronised.
// Notes:   The MAC makes the transmit clock and the RMII reference.
`timescale 1ns/1ns
`default_nettype none
module msp_mac_end
    import msp_pkg::*;
(
    // System
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Configuration
    input  wire msp_mode_t  i_mode,
    input  wire msp_speed_t i_speed,
    // Transmit data from the user
    input  wire logic [3:0] i_tx_rise,
    input  wire logic [3:0] i_tx_fall,
    input  wire logic       i_tx_ctl_rise,
    input  wire logic       i_tx_ctl_fall,
    output logic            o_tx_take,
    // Fibre module status driven in 1000BASE-X
    input  wire logic       i_fibre_signal_present,
    // Receive data toward the user
    output logic [3:0]      o_rx_rise,
    output logic [3:0]      o_rx_fall,
    output logic            o_rx_ctl_rise,
    output logic            o_rx_ctl_fall,
    output logic            o_rx_strobe,
    // Link pins
    msp_pins_if.mac         pins
);

    logic [7:0] cnt;
    logic       clk_q;
    logic [2:0] low_q;
    logic       bit3_q;
    logic       ctl_q;
    logic       take;
    logic       drive;
    logic [7:0] per;
    logic [7:0] next_cnt;
    logic       next_clk;
    logic [2:0] next_low;
    logic       next_bit3;
    logic       next_ctl;
    logic       next_take;
    logic       next_drive;
    logic       tx_mode;
    logic [2:0] rclk_s;
    logic [1:0] rctl_s;
    logic [3:0] rbits_s0;
    logic [3:0] rbits_s1;
    logic [3:0] rx_rise;
    logic [3:0] rx_fall;
    logic       rctl_rise;
    logic       rctl_fall;
    logic       rx_strobe;
    logic [3:0] next_rx_rise;
    logic [3:0] next_rx_fall;
    logic       next_rctl_rise;
    logic       next_rctl_fall;
    logic       next_rx_strobe;

    assign tx_mode = (i_mode == MSP_RGMII) || (i_mode == MSP_RTBI) ||
                     (i_mode == MSP_RMII);

    // Transmit clock and data launched together on its edges.
    always_comb begin
        per        = msp_period(i_mode, i_speed);
        next_cnt   = msp_count_next(cnt, per);
        next_clk   = msp_level(next_cnt, per);
        next_drive = tx_mode;
        next_low   = low_q;
        next_bit3  = bit3_q;
        next_ctl   = ctl_q;
        next_take  = 1'b0;
        if (i_mode == MSP_BASEX) begin
            next_bit3 = i_fibre_signal_present;
        end else if (!tx_mode) begin
            next_low  = 3'h0;
            next_bit3 = 1'b0;
            next_ctl  = 1'b0;
        end else if (next_clk & ~clk_q) begin
            next_low  = i_tx_rise[2:0];
            next_bit3 = (i_mode != MSP_RMII) & i_tx_rise[3];
            next_ctl  = i_tx_ctl_rise;
            next_take = (i_mode == MSP_RMII);
        end else if (~next_clk & clk_q & (i_mode != MSP_RMII)) begin
            next_low  = i_tx_fall[2:0];
            next_bit3 = i_tx_fall[3];
            next_ctl  = i_tx_ctl_fall;
            next_take = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt    <= 8'h00;
            clk_q  <= 1'b0;
            low_q  <= 3'h0;
            bit3_q <= 1'b0;
            ctl_q  <= 1'b0;
            take   <= 1'b0;
            drive  <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            clk_q  <= next_clk;
            low_q  <= next_low;
            bit3_q <= next_bit3;
            ctl_q  <= next_ctl;
            take   <= next_take;
            drive  <= next_drive;
        end
    end

    // Receive pins pass two flops before any logic reads them.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rclk_s   <= 3'h0;
            rctl_s   <= 2'h0;
            rbits_s0 <= 4'h0;
            rbits_s1 <= 4'h0;
        end else begin
            rclk_s   <= {rclk_s[1:0], pins.phy_receive_timing_clock};
            rctl_s   <= {rctl_s[0], pins.receive_enable_control};
            rbits_s0 <= pins.receive_bits;
            rbits_s1 <= rbits_s0;
        end
    end

    // RMII receive uses the own reference, which lags one period.
    always_comb begin
        next_rx_rise   = rx_rise;
        next_rx_fall   = rx_fall;
        next_rctl_rise = rctl_rise;
        next_rctl_fall = rctl_fall;
        next_rx_strobe = 1'b0;
        if (i_mode == MSP_RMII) begin
            if (next_clk & ~clk_q) begin
                next_rx_rise   = rbits_s1;
                next_rctl_rise = rctl_s[1];
                next_rx_strobe = 1'b1;
            end
        end else if (tx_mode) begin
            if (rclk_s[1] & ~rclk_s[2]) begin
                next_rx_rise   = rbits_s1;
                next_rctl_rise = rctl_s[1];
            end
            if (~rclk_s[1] & rclk_s[2]) begin
                next_rx_fall   = rbits_s1;
                next_rctl_fall = rctl_s[1];
                next_rx_strobe = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_rise   <= 4'h0;
            rx_fall   <= 4'h0;
            rctl_rise <= 1'b0;
            rctl_fall <= 1'b0;
            rx_strobe <= 1'b0;
        end else begin
            rx_rise   <= next_rx_rise;
            rx_fall   <= next_rx_fall;
            rctl_rise <= next_rctl_rise;
            rctl_fall <= next_rctl_fall;
            rx_strobe <= next_rx_strobe;
        end
    end

    // Outputs and pins straight from registers, except bit3_mac_oe, which also decodes i_mode.
    assign o_tx_take                    = take;
    assign o_rx_rise                    = rx_rise;
    assign o_rx_fall                    = rx_fall;
    assign o_rx_ctl_rise                = rctl_rise;
    assign o_rx_ctl_fall                = rctl_fall;
    assign o_rx_strobe                  = rx_strobe;
    assign pins.clk_mac_o               = clk_q;
    assign pins.clk_mac_oe              = drive;
    assign pins.bit3_mac_o              = bit3_q;
    assign pins.bit3_mac_oe             = drive | (i_mode == MSP_BASEX);
    assign pins.transmit_enable_control = ctl_q;
    assign pins.transmit_low_bits       = low_q;

endmodule
`default_nettype wire

// >>> verif/msp_chk.sv
// Purpose: Concurrent checks on the shared MAC-side pins.
// Assumes: Mode and speed change only while reset is high.
// Notes:   Counts are system clock cycles.
`timescale 1ns/1ns
`default_nettype none
module msp_chk
    import msp_pkg::*;
(
    // System and configuration
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire msp_mode_t  i_mode,
    input wire msp_speed_t i_speed,
    // Pins
    input wire logic       clk_phy_o,
    input wire logic       clk_phy_oe,
    input wire logic       bit3_phy_o,
    input wire logic       bit3_phy_oe,
    input wire logic       mac_transmit_timing_clock,
    input wire logic       transmit_bit3_pin,
    input wire logic       phy_receive_timing_clock,
    input wire logic       receive_enable_control,
    input wire logic [3:0] receive_bits
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [2:0] age;
    wire        tc = mac_transmit_timing_clock;
    wire        rc = phy_receive_timing_clock;
    wire        up = age > 3'h3;
    wire        gig = i_mode == MSP_RTBI ||
                      (i_mode == MSP_RGMII && i_speed == MSP_SPD_1000);

    // Age since reset; the dividers need a few cycles to settle.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end

    // Reference clock shape: three cycles high, two low.
    sequence s_ref(c);
        c[*3] ##1 (!c)[*2] ##1 c;
    endsequence

    a_gig_tx_toggle: assert property (up && gig |-> tc != $past(tc))
        else $error("tx clock not at gigabit rate");
    a_gig_rx_toggle: assert property (up && gig |-> rc != $past(rc))
        else $error("rx clock not at gigabit rate");
    a_fast_tx_shape: assert property (up && i_mode == MSP_RGMII &&
        i_speed == MSP_SPD_100 && $rose(tc) |-> tc[*5] ##1 (!tc)[*5] ##1 tc)
        else $error("tx clock period wrong at 100");
    a_ref_tx_shape: assert property (up && i_mode == MSP_RMII &&
        $rose(tc) |-> s_ref(tc)) else $error("reference clock shape wrong");
    a_ref_rx_shape: assert property (up && i_mode == MSP_RMII &&
        $rose(rc) |-> s_ref(rc)) else $error("rx reference shape wrong");
    a_serial_clock_pair: assert property (up && i_mode == MSP_SGMII |->
        bit3_phy_o != clk_phy_o && clk_phy_o != $past(clk_phy_o))
        else $error("serial clock pair wrong");
    a_idle_rx_low: assert property (i_mode inside {MSP_SGMII, MSP_BASEX}
        |-> !rc && !receive_enable_control && receive_bits == 4'h0)
        else $error("rx pins not held low");
    a_rmii_bit3_low: assert property (i_mode == MSP_RMII |->
        !transmit_bit3_pin) else $error("bit3 pin not low");
    a_pin_direction: assert property (up |-> bit3_phy_oe == clk_phy_oe &&
        clk_phy_oe == (i_mode == MSP_SGMII)) else $error("pin direction wrong");
endmodule
`default_nettype wire

// >>> verif/mac_side_interface_pin_mux_tb.sv
// Purpose: Both pin-mux ends joined back to back, checked per mode.
// Assumes: Each mode is entered under a fresh reset.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module mac_side_interface_pin_mux_tb;
    import msp_pkg::*;
    logic       i_sys_clk = 1'b0;
    logic       i_rst = 1'b1;
    msp_mode_t  i_mode = MSP_RGMII;
    msp_speed_t i_speed = MSP_SPD_1000;
    logic       i_fifty_mhz_clock_output_enable = 1'b0;
    logic       i_detect_active_low = 1'b0;
    logic       i_fibre_signal_present = 1'b0;
    logic [3:0] i_tx_rise = 4'h0;
    logic [3:0] i_tx_fall = 4'h0;
    wire        i_tx_ctl_rise = i_tx_rise[0];
    wire        i_tx_ctl_fall = i_tx_fall[0];
    wire  [3:0] i_rx_rise = i_tx_fall;
    wire  [3:0] i_rx_fall = i_tx_rise;
    wire        i_rx_ctl_rise = i_tx_fall[0];
    wire        i_rx_ctl_fall = i_tx_rise[0];
    logic [3:0] o_tx_rise, o_tx_fall, o_rx_rise, o_rx_fall;
    logic       o_tx_ctl_rise, o_tx_ctl_fall, o_tx_strobe, o_rx_take;
    logic       o_rx_ctl_rise, o_rx_ctl_fall, o_rx_strobe, o_tx_take;
    logic       o_fibre_signal_present;
    int         error_cnt = 0;
    int         total_checks = 0;
    int         tn = 0;

    msp_pins_if pins ();
    wire        tc = pins.mac_transmit_timing_clock;
    wire        rc = pins.phy_receive_timing_clock;
    wire        t3 = pins.transmit_bit3_pin;
    msp_phy_end u_msp_phy_end (.i_sys_clk, .i_rst, .i_mode, .i_speed,
        .i_fifty_mhz_clock_output_enable, .i_detect_active_low, .o_tx_rise, .o_tx_fall,
        .o_tx_ctl_rise, .o_tx_ctl_fall, .o_tx_strobe, .i_rx_rise,
        .i_rx_fall, .i_rx_ctl_rise, .i_rx_ctl_fall, .o_rx_take,
        .o_fibre_signal_present, .pins);
    msp_mac_end u_msp_mac_end (.i_sys_clk, .i_rst, .i_mode, .i_speed,
        .i_tx_rise, .i_tx_fall, .i_tx_ctl_rise, .i_tx_ctl_fall, .o_tx_take,
        .i_fibre_signal_present, .o_rx_rise, .o_rx_fall, .o_rx_ctl_rise,
        .o_rx_ctl_fall, .o_rx_strobe, .pins);
    msp_chk u_msp_chk (.i_sys_clk, .i_rst, .i_mode, .i_speed,
        .clk_phy_o (pins.clk_phy_o), .clk_phy_oe (pins.clk_phy_oe),
        .bit3_phy_o (pins.bit3_phy_o), .bit3_phy_oe (pins.bit3_phy_oe),
        .mac_transmit_timing_clock (tc), .transmit_bit3_pin (t3),
        .phy_receive_timing_clock (rc),
        .receive_enable_control (pins.receive_enable_control),
        .receive_bits (pins.receive_bits));

    // System clock, 4 ns period.
    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic fin();
        tn++;
        $display("test %0d done", tn);
    endtask

    // Mode and speed are only changed under reset.
    task automatic start(input msp_mode_t m, input msp_speed_t s);
        @(negedge i_sys_clk);
        i_rst = 1'b1;
        i_mode = m;
        i_speed = s;
        repeat (16) @(negedge i_sys_clk);
        i_rst = 1'b0;
    endtask

    // The first strobe may carry a pair launched before data settled.
    // Bit 0 of w picks the rx side, bit 1 the take pulse over the strobe.
    task automatic await(input logic [1:0] w);
        int k;
        k = 0;
        repeat (2) begin
            @(negedge i_sys_clk);
            while ((w[1] ? (w[0] ? o_rx_take : o_tx_take) :
                    (w[0] ? o_rx_strobe : o_tx_strobe)) !== 1'b1) begin
                @(negedge i_sys_clk);
                k++;
                if (k > 600) begin
                    error_cnt++;
                    tally_and_finish();
                end
            end
        end
    endtask

    task automatic xfer(input msp_mode_t m, input msp_speed_t s,
                        input logic [3:0] a, input logic [3:0] b);
        logic [3:0] k;
        k = (m == MSP_RMII) ? 4'h3 : 4'hF;
        i_tx_rise = a;
        i_tx_fall = b;
        start(m, s);
        // At gigabit the first clock rise only comes at the second edge.
        @(negedge i_sys_clk);
        repeat (12) begin
            @(negedge i_sys_clk);
            if (m != MSP_RMII) begin
                check({t3, pins.transmit_low_bits}, tc ? a : b);
                check(pins.receive_bits, rc ? b : a);
            end
        end
        await(2'h0);
        check(o_tx_rise, a & k);
        await(2'h1);
        check(o_rx_rise, b & k);
        if (m != MSP_RMII) begin
            check(o_tx_fall, b);
            check(o_rx_fall, a);
            check({o_tx_ctl_rise, o_tx_ctl_fall, o_rx_ctl_rise, o_rx_ctl_fall},
                  {a[0], b[0], b[0], a[0]});
        end
        // Each take pulse stands with the half it has just launched.
        await(2'h3);
        check(pins.receive_bits, (m == MSP_RMII) ? b & k : a);
        await(2'h2);
        check({t3, pins.transmit_low_bits},
              (m == MSP_RMII) ? a & 4'h7 : b);
        fin();
    endtask

    // Main sequence: each interface type in turn.
    initial begin
        xfer(MSP_RGMII, MSP_SPD_1000, 4'hA, 4'h5);
        xfer(MSP_RGMII, MSP_SPD_100, 4'h6, 4'h9);
        xfer(MSP_RGMII, MSP_SPD_10, 4'hC, 4'h3);
        xfer(MSP_RTBI, MSP_SPD_1000, 4'h8, 4'h7);
        i_fifty_mhz_clock_output_enable = 1'b1;
        xfer(MSP_RMII, MSP_SPD_1000, 4'hF, 4'hE);
        start(MSP_SGMII, MSP_SPD_1000);
        repeat (8) @(negedge i_sys_clk);
        check({rc, t3 ^ tc, o_tx_strobe, o_tx_rise[0]}, 4'h4);
        fin();
        start(MSP_BASEX, MSP_SPD_1000);
        for (int i = 0; i < 4; i++) begin
            i_fibre_signal_present = i[0];
            i_detect_active_low = i[1];
            repeat (6) @(negedge i_sys_clk);
            check({3'h0, o_fibre_signal_present}, {3'h0, i[0] ^ i[1]});
        end
        fin();
        tally_and_finish();
    end
endmodule
`default_nettype wire
